// *** inc/acp_pkg.sv ***
// How it works
// - Select low enables serial traffic.
// - Select rise commits shifted byte to command.
// - Select fall preloads output shift register.
// - Data output floats while select high.
// - Input sampled on shift-clock rise, top_bit first.
// - Output shifts on shift-clock fall, top_bit first.
// - User output pins set by command.
// - Conversion timed by oscillator input clock.
// - End-of-conversion output rises at conversion end.
package acp_pkg;

   // Byte framing
   localparam int unsigned ACP_BYTE_W = 8;
   localparam int unsigned ACP_TOP_BIT = 7;
   localparam logic [3:0] ACP_BITS_PER_FRAME = 4'h8;

   // Command byte layout: index in the top two bits, payload below
   localparam int unsigned ACP_CMD_IDX_MSB = 7;
   localparam int unsigned ACP_CMD_IDX_LSB = 6;
   localparam int unsigned ACP_CMD_DATA_W = 6;

   // Command register indexes
   localparam logic [1:0] ACP_CMD_PINS = 2'h0;
   localparam logic [1:0] ACP_CMD_OUTSEL = 2'h1;
   localparam logic [1:0] ACP_CMD_CONV = 2'h2;
   localparam int unsigned ACP_CMD_DEPTH = 4;

   // Field positions inside command payloads
   localparam int unsigned ACP_PINS_W = 4;
   localparam int unsigned ACP_OUTSEL_W = 2;
   localparam int unsigned ACP_CONV_RUN_BIT = 0;
   localparam int unsigned ACP_CONV_50HZ_BIT = 1;

   // Reset values
   localparam logic [5:0] ACP_CMD_RESET = 6'h00;
   localparam logic [7:0] ACP_OUT_RESET = 8'h00;

   // Output register selection
   localparam logic [1:0] ACP_OUT_STATUS = 2'h0;
   localparam logic [1:0] ACP_OUT_HI = 2'h1;
   localparam logic [1:0] ACP_OUT_MID = 2'h2;
   localparam logic [1:0] ACP_OUT_LO = 2'h3;

   // Integration lengths in oscillator periods for 60 Hz and 50 Hz modes
   localparam logic [9:0] ACP_INT_60HZ = 10'h221;
   localparam logic [9:0] ACP_INT_50HZ = 10'h28F;

   // Result width: 18 bits plus sign
   localparam int unsigned ACP_RESULT_W = 19;

   // Sampled host pins
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } acp_pins_s;

   // Command byte split into its fields
   typedef struct packed {
      logic [1:0] idx;
      logic [5:0] data;
   } acp_cmd_s;

   // Conversion sequencer states
   typedef enum logic [2:0] {
      ACP_IDLE = 3'b001,
      ACP_INTEG = 3'b010,
      ACP_DONE = 3'b100
   } acp_conv_e;

endpackage

// *** testbench/acp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial port; shift clock stands low between frames
module acp_host_model #(
   parameter int HALF = 10 // Shift clock half period in core cycles (80 ns period)
) (
   input wire logic clk, // Core clock, pacing only
   output logic cs_n, // Select, active low
   output logic sclk, // Shift clock
   output logic din, // Serial data to device
   input wire logic dout_line // Resolved serial data line
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end

   // One frame of nbits bits, top_bit first; fewer than 8 only on purpose
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      repeat (300) @(posedge clk); // Select high time between frames
      cs_n <= 1'b0;
      repeat (125) @(posedge clk);
      for (int i = 7; i > 7 - nbits; i--) begin
         din <= tx[i];
         repeat (HALF) @(posedge clk);
         rx = {rx[6:0], dout_line}; // Taken as the clock rises
         sclk <= 1'b1;
         repeat (HALF) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge clk);
      cs_n <= 1'b1;
      din <= ~din; // Released data shows no stale level
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// *** testbench/acp_serial_port_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks on the serial port, bound into the design top
module acp_serial_port_chk
   import acp_pkg::*;
#(
   parameter int unsigned RESULT_W = ACP_RESULT_W
) (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Reset, active low
   input wire logic cs_n, // Select pin
   input wire logic sclk, // Shift clock pin
   input wire logic din, // Serial data in
   input wire logic dout_o, // Serial data out level
   input wire logic dout_oe, // Serial data out enable
   input wire logic osc_input, // Oscillator pin
   input wire logic osc_output, // Oscillator feedback
   input wire logic [RESULT_W-1:0] result_in, // Converted value
   input wire logic eoc, // End of conversion
   input wire logic [ACP_PINS_W-1:0] user_output_pins // User outputs
);
   // One domain only, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_OE_ON: assert property ($fell(cs_n) ##1 !cs_n [*5] |-> dout_oe)
      else $error("data out not driven after select fall");
   AST_OE_OFF: assert property (cs_n [*6] |-> !dout_oe)
      else $error("data out driven while deselected");
   AST_OE_CAUSE: assert property ($rose(dout_oe) |-> !cs_n && !$past(cs_n, 2))
      else $error("data out enabled without select");
   // Output may only move after a select fall or a shift-clock fall, never while the shift clock is high
   AST_DOUT_HOLD: assert property ((!cs_n && sclk) [*6] |-> $stable(dout_o))
      else $error("data out moved while shift clock high");
   // Pins change only in the short commit window after select rises
   AST_PINS_WIN: assert property ($changed(user_output_pins) |-> cs_n && !$past(cs_n, 14))
      else $error("user pins changed outside commit");
   AST_EOC_CLR: assert property ($fell(eoc) |-> !cs_n)
      else $error("end of conversion cleared without select");
   AST_EOC_HOLD: assert property (eoc && cs_n |=> eoc)
      else $error("end of conversion dropped while idle");
   AST_OSC_FB: assert property ($rose(osc_input) ##1 osc_input [*4] |-> !osc_output)
      else $error("oscillator feedback not inverted");
endmodule

bind acp_serial_port acp_serial_port_chk #(.RESULT_W(RESULT_W)) u_chk (
   .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
   .dout_o(dout_o), .dout_oe(dout_oe), .osc_input(osc_input),
   .osc_output(osc_output), .result_in(result_in), .eoc(eoc),
   .user_output_pins(user_output_pins)
);
`default_nettype wire

// *** testbench/test_adc_serial_command_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the converter's serial host port
module test_adc_serial_command_port;
   import acp_pkg::*;
   logic clk, rst_n, cs_n, sclk, din;
   logic osc_input = 1'b0; // Oscillator pin level
   logic last_q = 1'b0; // Last level driven on data out
   logic dout_o, dout_oe, osc_output, eoc;
   logic [ACP_PINS_W-1:0] user_output_pins;
   logic [ACP_RESULT_W-1:0] result = 19'h5A3C1; // Fixed converted value
   logic [2:0] oc = 3'h0; // Oscillator divider
   logic dout_line; // Resolved data line
   int err_count = 0;
   int n_checks = 0;

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Oscillator at 25 MHz, ten core cycles a period, to keep runs short
   always @(posedge clk) begin
      oc <= (oc == 3'h4) ? 3'h0 : oc + 3'h1;
      if (oc == 3'h4) osc_input <= ~osc_input;
   end

   // Released line shows the inverse of the last driven bit
   always @(posedge clk) if (dout_oe) last_q <= dout_o;
   assign dout_line = dout_oe ? dout_o : ~last_q;

   acp_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout_line(dout_line));

   acp_serial_port uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout_o(dout_o), .dout_oe(dout_oe), .osc_input(osc_input), .osc_output(osc_output),
      .result_in(result), .eoc(eoc), .user_output_pins(user_output_pins));

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Outputs while reset is held
   task automatic t_reset();
      `CHK("oe in reset", 1'b0, dout_oe)
      `CHK("pins in reset", 4'h0, user_output_pins)
      `CHK("eoc in reset", 1'b0, eoc)
      `CHK("osc fb in reset", 1'b1, osc_output)
   endtask

   // Pin commands, each level held after the frame
   task automatic t_pins();
      logic [7:0] rx;
      logic [3:0] v[4] = '{4'hA, 4'h5, 4'hF, 4'h0};
      for (int i = 0; i < 4; i++) begin
         host.xfer({ACP_CMD_PINS, 2'h0, v[i]}, 8, rx);
         repeat (20) @(posedge clk);
         `CHK("pins", v[i], user_output_pins)
         `CHK("status idle", 8'h00, rx)
         `CHK("oe after frame", 1'b0, dout_oe)
      end
   endtask

   // A short frame must not commit
   task automatic t_partial();
      logic [7:0] rx;
      host.xfer({ACP_CMD_PINS, 6'h09}, 5, rx);
      repeat (20) @(posedge clk);
      `CHK("pins after short", 4'h0, user_output_pins)
   endtask

   // Bounded wait for end of conversion; running out counts as a mismatch
   task automatic wait_eoc(output int n);
      n = 0;
      while (eoc !== 1'b1 && n < 7000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 7000) begin
         err_count++;
         final_report();
      end
   endtask

   // Conversion length in both line modes, then status read clears eoc
   task automatic t_conv();
      int n, tk;
      logic [7:0] rx;
      for (int m = 0; m < 2; m++) begin
         tk = m ? 655 : 545;
         host.xfer({ACP_CMD_CONV, 4'h0, m[0], 1'b1}, 8, rx);
         wait_eoc(n);
         `CHK("conv length", 1'b1, n >= tk * 10 - 10 && n <= tk * 10 + 50)
         // Run is still set at the end, so a further conversion is already under way
         host.xfer({ACP_CMD_CONV, 6'h00}, 8, rx);
         `CHK("status eoc", 8'h80, rx)
         repeat (10) @(posedge clk);
         `CHK("eoc cleared", 1'b0, eoc)
         // Let that trailing conversion finish and clear its flag too
         wait_eoc(n);
         host.xfer({ACP_CMD_CONV, 6'h00}, 8, rx);
         `CHK("status eoc again", 8'h80, rx)
      end
   endtask

   // Each selection is preloaded by the next frame's select fall
   task automatic t_result();
      logic [7:0] rx;
      logic [23:0] z = {5'h00, result};
      logic [1:0] sel[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      logic [7:0] ex[4];
      ex = '{8'h00, z[23:16], z[15:8], z[7:0]};
      for (int i = 0; i < 4; i++) begin
         host.xfer({ACP_CMD_OUTSEL, 4'h0, sel[i]}, 8, rx);
         `CHK("read byte", ex[i], rx)
      end
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      t_reset();
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      t_pins();
      t_partial();
      t_conv();
      t_result();
      final_report();
   end
endmodule
`default_nettype wire

// *** verilog/acp_cmd_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// Small command register store with one write and one registered read port
module acp_cmd_mem
   import acp_pkg::*;
#(
   parameter int unsigned WIDTH = ACP_CMD_DATA_W,
   parameter int unsigned DEPTH = ACP_CMD_DEPTH
) (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic wr_valid, // Write request
   output logic wr_ready, // Write accepted this cycle
   input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write index
   input wire logic [WIDTH-1:0] wr_data, // Write payload
   input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read index
   output logic [WIDTH-1:0] rd_data // Registered read data
);

   logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words

   // Always able to take a write; kept as a port so a slower store can stall
   assign wr_ready = 1'b1;

   // Storage update, cleared at reset so pins come up known
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= WIDTH'(ACP_CMD_RESET);
         end
      end else if (wr_valid) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Read data leaves from a register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= WIDTH'(ACP_CMD_RESET);
      end else begin
         rd_data <= mem_q[rd_addr];
      end
   end

endmodule
`default_nettype wire

// *** verilog/acp_serial_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Serial host port of an integrating converter, sampled by the core clock
module acp_serial_port
   import acp_pkg::*;
#(
   parameter int unsigned RESULT_W = ACP_RESULT_W
) (
   input wire logic clk, // Core clock, 250 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic cs_n, // Host select pin, active low
   input wire logic sclk, // Host shift clock pin
   input wire logic din, // Host serial data pin
   output logic dout_o, // Serial data out level
   output logic dout_oe, // Serial data out enable, high while driving
   input wire logic osc_input, // Oscillator input pin
   output logic osc_output, // Oscillator feedback output
   input wire logic [RESULT_W-1:0] result_in, // Converted value from analog core
   output logic eoc, // End of conversion
   output logic [ACP_PINS_W-1:0] user_output_pins // User programmable outputs
);

   // Two-flop synchronisers for host pins and oscillator
   acp_pins_s pins_meta_q; // First stage, read only by second stage
   acp_pins_s pins_q; // Second stage, safe to use
   acp_pins_s pins_d1_q; // One cycle older copy for edge finding
   logic osc_meta_q; // First oscillator stage
   logic osc_q; // Second oscillator stage
   logic osc_d1_q; // Older oscillator copy

   // Edge strobes
   logic cs_fall; // Select went low
   logic cs_rise; // Select went high
   logic sclk_rise; // Shift clock rising inside a frame
   logic sclk_fall; // Shift clock falling inside a frame
   logic osc_tick; // One oscillator period elapsed

   // Serial shifting
   logic [ACP_BYTE_W-1:0] in_sh_q; // Input shift register
   logic [ACP_BYTE_W-1:0] out_sh_q; // Output shift register
   logic [ACP_BYTE_W-1:0] preload_word; // Output register chosen for the next frame
   logic [3:0] bit_cnt_q; // Bits received in this frame

   // Two-entry command buffer
   acp_cmd_s buf_q [2]; // Buffer entries
   logic [1:0] buf_cnt_q; // Entries held
   logic buf_wr_ptr_q; // Fill pointer
   logic buf_rd_ptr_q; // Drain pointer
   logic buf_in_valid; // Byte offered to buffer
   logic buf_in_ready; // Commit pending and buffer has room
   logic buf_out_valid; // Buffer holds a byte
   logic buf_out_ready; // Store takes the byte
   logic commit_pend_q; // Committed byte waiting for room
   acp_cmd_s commit_q; // Byte waiting for room

   // Command store and its shadows
   logic [1:0] rd_addr_q; // Read index walking the store
   logic [1:0] rd_addr_d1_q; // Index whose data is now on rd_data
   logic [ACP_CMD_DATA_W-1:0] rd_data; // Store read data
   logic [ACP_OUTSEL_W-1:0] out_sel_q; // Selected output register
   logic conv_run_q; // Conversions enabled
   logic mode_50hz_q; // Long integration selected

   // Conversion sequencer
   acp_conv_e conv_q; // Sequencer state
   logic [9:0] tick_cnt_q; // Oscillator periods counted
   logic [RESULT_W-1:0] result_q; // Latched result
   logic conv_end; // Last period of integration

   // Sample pins twice before any use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_meta_q <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
         pins_q <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
         pins_d1_q <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      end else begin
         pins_meta_q <= '{cs_n: cs_n, sclk: sclk, din: din};
         pins_q <= pins_meta_q;
         pins_d1_q <= pins_q;
      end
   end

   // Oscillator pin is sampled the same way as host pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_meta_q <= 1'b0;
         osc_q <= 1'b0;
         osc_d1_q <= 1'b0;
      end else begin
         osc_meta_q <= osc_input;
         osc_q <= osc_meta_q;
         osc_d1_q <= osc_q;
      end
   end

   // Edge detection only on synchronised copies
   assign cs_fall = pins_d1_q.cs_n && !pins_q.cs_n;
   assign cs_rise = !pins_d1_q.cs_n && pins_q.cs_n;
   assign sclk_rise = !pins_q.cs_n && !pins_d1_q.sclk && pins_q.sclk;
   assign sclk_fall = !pins_q.cs_n && pins_d1_q.sclk && !pins_q.sclk;
   assign osc_tick = !osc_d1_q && osc_q;

   // Crystal feedback: inverted copy of the oscillator input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_output <= 1'b1;
      end else begin
         osc_output <= !osc_q;
      end
   end

   // Input shifting, top_bit arrives first so shift toward the top
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_sh_q <= ACP_OUT_RESET;
         bit_cnt_q <= 4'h0;
      end else if (cs_fall) begin
         bit_cnt_q <= 4'h0;
      end else if (sclk_rise) begin
         in_sh_q <= {in_sh_q[ACP_TOP_BIT-1:0], pins_q.din};
         if (bit_cnt_q != ACP_BITS_PER_FRAME) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
      end
   end

   // Output register chosen by the last selection command
   function automatic logic [ACP_BYTE_W-1:0] out_word(input logic [1:0] sel,
                                                       input logic done,
                                                       input logic [RESULT_W-1:0] res);
      logic [23:0] wide;
      wide = 24'(res);
      case (sel)
         ACP_OUT_STATUS: out_word = {done, 7'h00};
         ACP_OUT_HI: out_word = wide[23:16];
         ACP_OUT_MID: out_word = wide[15:8];
         default: out_word = wide[7:0];
      endcase
   endfunction

   // One copy of the preload word feeds both the shifter and the pin
   assign preload_word = out_word(out_sel_q, eoc, result_q);

   // Preload at select fall, then shift on each falling shift edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_sh_q <= ACP_OUT_RESET;
      end else if (cs_fall) begin
         out_sh_q <= preload_word;
      end else if (sclk_fall) begin
         out_sh_q <= {out_sh_q[ACP_TOP_BIT-1:0], 1'b0};
      end
   end

   // Pin drive: enabled only inside a frame, top bit always on the pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout_oe <= 1'b0;
         dout_o <= 1'b0;
      end else begin
         dout_oe <= !pins_q.cs_n;
         if (cs_fall) begin
            dout_o <= preload_word[ACP_TOP_BIT];
         end else if (sclk_fall) begin
            dout_o <= out_sh_q[ACP_TOP_BIT-1];
         end
      end
   end

   // Commit at select rise; a partial byte is dropped, not half applied
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         commit_pend_q <= 1'b0;
         commit_q <= '{idx: 2'h0, data: ACP_CMD_RESET};
      end else if (cs_rise && bit_cnt_q == ACP_BITS_PER_FRAME) begin
         commit_pend_q <= 1'b1;
         commit_q <= acp_cmd_s'(in_sh_q);
      end else if (buf_in_ready) begin
         commit_pend_q <= 1'b0;
      end
   end

   // Stalled commits wait here; a new frame during a stall overwrites it
   assign buf_in_valid = commit_pend_q;
   assign buf_in_ready = commit_pend_q && (buf_cnt_q != 2'h2);
   assign buf_out_valid = (buf_cnt_q != 2'h0);

   // Two-entry buffer between the serial side and the command store
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_cnt_q <= 2'h0;
         buf_wr_ptr_q <= 1'b0;
         buf_rd_ptr_q <= 1'b0;
         buf_q[0] <= '{idx: 2'h0, data: ACP_CMD_RESET};
         buf_q[1] <= '{idx: 2'h0, data: ACP_CMD_RESET};
      end else begin
         if (buf_in_valid && buf_in_ready) begin
            buf_q[buf_wr_ptr_q] <= commit_q;
            buf_wr_ptr_q <= !buf_wr_ptr_q;
         end
         if (buf_out_valid && buf_out_ready) begin
            buf_rd_ptr_q <= !buf_rd_ptr_q;
         end
         case ({buf_in_valid && buf_in_ready, buf_out_valid && buf_out_ready})
            2'b10: buf_cnt_q <= buf_cnt_q + 2'h1;
            2'b01: buf_cnt_q <= buf_cnt_q - 2'h1;
            default: buf_cnt_q <= buf_cnt_q;
         endcase
      end
   end

   // Command store
   acp_cmd_mem #(
      .WIDTH(ACP_CMD_DATA_W),
      .DEPTH(ACP_CMD_DEPTH)
   ) u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .wr_valid(buf_out_valid),
      .wr_ready(buf_out_ready),
      .wr_addr(buf_q[buf_rd_ptr_q].idx),
      .wr_data(buf_q[buf_rd_ptr_q].data),
      .rd_addr(rd_addr_q),
      .rd_data(rd_data)
   );

   // Walk the store so every shadow refreshes within four cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_addr_q <= 2'h0;
         rd_addr_d1_q <= 2'h0;
      end else begin
         rd_addr_q <= rd_addr_q + 2'h1;
         rd_addr_d1_q <= rd_addr_q;
      end
   end

   // Shadows that steer pins, preload and conversions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         user_output_pins <= ACP_PINS_W'(ACP_CMD_RESET);
         out_sel_q <= ACP_OUT_STATUS;
         conv_run_q <= 1'b0;
         mode_50hz_q <= 1'b0;
      end else begin
         case (rd_addr_d1_q)
            ACP_CMD_PINS: user_output_pins <= rd_data[ACP_PINS_W-1:0];
            ACP_CMD_OUTSEL: out_sel_q <= rd_data[ACP_OUTSEL_W-1:0];
            ACP_CMD_CONV: begin
               conv_run_q <= rd_data[ACP_CONV_RUN_BIT];
               mode_50hz_q <= rd_data[ACP_CONV_50HZ_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Conversion length counts oscillator periods, not core cycles
   assign conv_end = (conv_q == ACP_INTEG) && osc_tick &&
                     (tick_cnt_q == (mode_50hz_q ? ACP_INT_50HZ : ACP_INT_60HZ) - 10'h1);

   // Conversion sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_q <= ACP_IDLE;
         tick_cnt_q <= 10'h000;
      end else begin
         case (conv_q)
            ACP_IDLE: begin
               tick_cnt_q <= 10'h000;
               if (conv_run_q && osc_tick) begin
                  conv_q <= ACP_INTEG;
               end
            end
            ACP_INTEG: begin
               if (conv_end) begin
                  conv_q <= ACP_DONE;
               end else if (osc_tick) begin
                  tick_cnt_q <= tick_cnt_q + 10'h1;
               end
            end
            ACP_DONE: conv_q <= ACP_IDLE;
            default: conv_q <= ACP_IDLE;
         endcase
      end
   end

   // Result latch and end flag; a new end beats a read in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= '0;
         eoc <= 1'b0;
      end else if (conv_end) begin
         result_q <= result_in;
         eoc <= 1'b1;
      end else if (cs_fall) begin
         eoc <= 1'b0;
      end
   end

endmodule
`default_nettype wire
